// ==== hdl/iopr_top.sv ====
// Parallel port with remappable pin selection, write lock and shadow monitor.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
module iopr_top
	import iopr_pkg::*;
#(
	parameter bit SMALL_PKG = 1'b0
) (
	input wire logic clk_i, // System clock.
	input wire logic resetn_i, // Asynchronous reset, active low.
	input wire logic [AW-1:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte enables.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [AW-1:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire logic [7:0] osc_cfg_word_i, // Oscillator configuration word.
	input wire logic [NIO-1:0] pad_in_i, // Remappable pin levels.
	input wire logic [NRPI-1:0] rpi_in_i, // Input-only pin levels.
	output iopr_pad_t pad_o, // Pin drivers and enables.
	input wire logic [NFN-1:0] periph_out_i, // Peripheral output data.
	input wire logic [NFN-1:0] periph_drive_i, // Peripheral enabled and driving.
	output logic [NFN-1:0] periph_in_o, // Remapped peripheral inputs.
	output logic cfg_mismatch_reset_o // Configuration mismatch reset request.
);
	localparam logic [NIO-1:0] IO_IMPL = SMALL_PKG ? IO_IMPL_SMALL : IO_IMPL_FULL;
	localparam logic [NRPI-1:0] RPI_IMPL = SMALL_PKG ? RPI_IMPL_SMALL : RPI_IMPL_FULL;
	localparam logic [63:0] SRC_IMPL = {20'h0_0000, RPI_IMPL, IO_IMPL};

	// Registers.
	logic [NIO-1:0] dir_r;
	logic [NIO-1:0] lat_r;
	logic [SELW-1:0] imap_r [NFN];
	logic [SELW-1:0] omap_r [NIO];
	logic [SELW-1:0] imap_sh_r [NFN];
	logic [SELW-1:0] omap_sh_r [NIO];
	logic lock_r;
	logic set_once_r;
	logic one_way_r;
	logic cfg_done_r;
	iopr_ul_t ul_r;

	// Bus state.
	logic have_aw_r;
	logic have_w_r;
	logic [AW-1:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	// Pin sampling.
	logic [NIO+NRPI-1:0] sync1_r;
	logic [NIO+NRPI-1:0] sync2_r;
	logic [NIO+NRPI-1:0] sync3_r;
	logic [NIO+NRPI-1:0] filt_r;

	iopr_pad_t pad_r;
	logic [NFN-1:0] pin_r;
	logic mism_r;

	logic wr_go;
	logic rd_go;
	logic any_acc;
	logic osc_wr;
	logic [31:0] wmask;
	logic [NIO-1:0] io_lvl;
	logic [NRPI-1:0] rpi_lvl;
	logic [NIO-1:0] pdrv;
	logic [NIO-1:0] pval;
	logic [NIO-1:0] port_own;
	logic [63:0] src;
	logic mism;
	logic [31:0] rd_data;
	logic rd_err;
	logic wr_err;

	assign wr_go = have_aw_r & have_w_r & ~bvalid_r;
	assign rd_go = s_axi_arvalid & arready_r;
	assign any_acc = wr_go | rd_go;
	assign osc_wr = wr_go & (waddr_r == OFS_OSC) & wstrb_r[0];
	assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	assign io_lvl = filt_r[NIO-1:0];
	assign rpi_lvl = filt_r[NIO+NRPI-1:NIO];

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign pad_o = pad_r;
	assign periph_in_o = pin_r;
	assign cfg_mismatch_reset_o = mism_r;

	// Write side: address and data are taken in either order.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			have_aw_r <= 1'b0;
			have_w_r <= 1'b0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			waddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				have_aw_r <= 1'b1;
				awready_r <= 1'b0;
				waddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_r) begin
				have_w_r <= 1'b1;
				wready_r <= 1'b0;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				have_aw_r <= 1'b0;
				have_w_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_err ? RESP_SLVERR : RESP_OKAY;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// Write decode; unmapped addresses answer SLVERR.
	always_comb begin
		wr_err = 1'b1;
		if (waddr_r == OFS_DIR || waddr_r == OFS_LAT || waddr_r == OFS_PIN) begin
			wr_err = 1'b0;
		end
		if (waddr_r == OFS_OSC || waddr_r == OFS_STAT) begin
			wr_err = 1'b0;
		end
		if (waddr_r[AW-1:5] == OFS_IMAP[AW-1:5] && waddr_r[1:0] == 2'b00) begin
			wr_err = 1'b0;
		end
		if (waddr_r[AW-1:7] == OFS_OMAP[AW-1:7] && waddr_r[1:0] == 2'b00) begin
			wr_err = 1'b0;
		end
	end

	// Port direction and latch.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dir_r <= IO_IMPL;
			lat_r <= '0;
		end else if (wr_go) begin
			if (waddr_r == OFS_DIR) begin
				dir_r <= ((dir_r & ~wmask) | (wdata_r & wmask)) & IO_IMPL;
			end
			if (waddr_r == OFS_LAT || waddr_r == OFS_PIN) begin
				lat_r <= ((lat_r & ~wmask) | (wdata_r & wmask)) & IO_IMPL;
			end
		end
	end

	// Remap registers and their shadows, written together and only while unlocked.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < NFN; i++) begin
				imap_r[i] <= IMAP_RST;
				imap_sh_r[i] <= IMAP_RST;
			end
			for (int n = 0; n < NIO; n++) begin
				omap_r[n] <= OMAP_RST;
				omap_sh_r[n] <= OMAP_RST;
			end
		end else if (wr_go && !lock_r && wstrb_r[0]) begin
			if (waddr_r[AW-1:5] == OFS_IMAP[AW-1:5]) begin
				imap_r[waddr_r[4:2]] <= wdata_r[SELW-1:0];
				imap_sh_r[waddr_r[4:2]] <= wdata_r[SELW-1:0];
			end
			if (waddr_r[AW-1:7] == OFS_OMAP[AW-1:7] && IO_IMPL[waddr_r[6:2]]) begin
				omap_r[waddr_r[6:2]] <= wdata_r[SELW-1:0];
				omap_sh_r[waddr_r[6:2]] <= wdata_r[SELW-1:0];
			end
		end
	end

	// One-session setting is caught once, right after reset release.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_done_r <= 1'b0;
			one_way_r <= 1'b1;
		end else if (!cfg_done_r) begin
			cfg_done_r <= 1'b1;
			one_way_r <= osc_cfg_word_i[CFG_1WAY_BIT];
		end
	end

	// Unlock sequence and lock bit.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ul_r <= UL_IDLE;
			lock_r <= 1'b0;
			set_once_r <= 1'b0;
		end else begin
			unique case (ul_r)
				UL_IDLE: begin
					if (osc_wr && !rd_go && wdata_r[7:0] == UNLOCK_KEY1) begin
						ul_r <= UL_KEY1;
					end
				end
				UL_KEY1: begin
					if (any_acc) begin
						if (osc_wr && !rd_go && wdata_r[7:0] == UNLOCK_KEY2) begin
							ul_r <= UL_ARMED;
						end else begin
							ul_r <= UL_IDLE;
						end
					end
				end
				UL_ARMED: begin
					if (any_acc) begin
						ul_r <= UL_IDLE;
						if (osc_wr && !rd_go) begin
							if (wdata_r[OSC_LOCK_BIT] || !(one_way_r && set_once_r)) begin
								lock_r <= wdata_r[OSC_LOCK_BIT];
							end
							if (wdata_r[OSC_LOCK_BIT]) begin
								set_once_r <= 1'b1;
							end
						end
					end
				end
				default: begin
					ul_r <= UL_IDLE;
				end
			endcase
		end
	end

	// Pin sampling: three stages, a change counts when stages two and three agree.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
			filt_r <= '0;
		end else begin
			sync1_r <= {rpi_in_i, pad_in_i};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			for (int b = 0; b < NIO + NRPI; b++) begin
				if (sync2_r[b] == sync3_r[b]) begin
					filt_r[b] <= sync3_r[b];
				end
			end
		end
	end

	// Output ownership per pin; one field per pin means one function at most.
	always_comb begin
		pdrv = '0;
		pval = '0;
		for (int n = 0; n < NIO; n++) begin
			if (omap_r[n] != OMAP_RST && omap_r[n] <= SELW'(NFN) && IO_IMPL[n]) begin
				pdrv[n] = periph_drive_i[3'(omap_r[n] - 6'h01)];
				pval[n] = periph_out_i[3'(omap_r[n] - 6'h01)];
			end
		end
		port_own = IO_IMPL & ~dir_r & ~pdrv;
		src = {20'h0_0000, rpi_lvl, io_lvl & ~port_own} & SRC_IMPL;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pad_r <= '0;
			pin_r <= '0;
		end else begin
			pad_r.oe <= IO_IMPL & (pdrv | ~dir_r);
			pad_r.out <= IO_IMPL & ((pdrv & pval) | (~pdrv & lat_r));
			for (int i = 0; i < NFN; i++) begin
				pin_r[i] <= SRC_IMPL[imap_r[i]] & src[imap_r[i]];
			end
		end
	end

	// Shadow comparison runs every cycle.
	always_comb begin
		mism = 1'b0;
		for (int i = 0; i < NFN; i++) begin
			mism = mism | (imap_r[i] != imap_sh_r[i]);
		end
		for (int n = 0; n < NIO; n++) begin
			mism = mism | (omap_r[n] != omap_sh_r[n]);
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mism_r <= 1'b0;
		end else begin
			mism_r <= mism;
		end
	end

	// Read decode.
	always_comb begin
		rd_data = '0;
		rd_err = 1'b0;
		if (s_axi_araddr == OFS_DIR) begin
			rd_data = dir_r & IO_IMPL;
		end else if (s_axi_araddr == OFS_LAT) begin
			rd_data = lat_r & IO_IMPL;
		end else if (s_axi_araddr == OFS_PIN) begin
			rd_data = io_lvl & IO_IMPL;
		end else if (s_axi_araddr == OFS_OSC) begin
			rd_data[OSC_LOCK_BIT] = lock_r;
		end else if (s_axi_araddr == OFS_STAT) begin
			rd_data[ST_LOCK_BIT] = lock_r;
			rd_data[ST_ONCE_BIT] = set_once_r;
			rd_data[ST_1WAY_BIT] = one_way_r;
			rd_data[ST_ARMED_BIT] = (ul_r == UL_ARMED);
			rd_data[ST_MISM_BIT] = mism_r;
		end else if (s_axi_araddr[AW-1:5] == OFS_IMAP[AW-1:5] && s_axi_araddr[1:0] == 2'b00) begin
			rd_data[SELW-1:0] = imap_r[s_axi_araddr[4:2]];
		end else if (s_axi_araddr[AW-1:7] == OFS_OMAP[AW-1:7] && s_axi_araddr[1:0] == 2'b00) begin
			rd_data[SELW-1:0] = omap_r[s_axi_araddr[6:2]];
		end else begin
			rd_err = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else if (rd_go) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rd_data;
			rresp_r <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end
endmodule : iopr_top

// ==== inc/iopr_pkg.sv ====
// Constants, register map and carrier types for the pin port and remap block.
package iopr_pkg;
	localparam int NIO = 32;
	localparam int NRPI = 12;
	localparam int NFN = 8;
	localparam int SELW = 6;
	localparam int AW = 12;
	localparam logic [AW-1:0] OFS_DIR = 12'h000;
	localparam logic [AW-1:0] OFS_LAT = 12'h004;
	localparam logic [AW-1:0] OFS_PIN = 12'h008;
	localparam logic [AW-1:0] OFS_OSC = 12'h00C;
	localparam logic [AW-1:0] OFS_STAT = 12'h010;
	localparam logic [AW-1:0] OFS_IMAP = 12'h040;
	localparam logic [AW-1:0] OFS_OMAP = 12'h080;
	localparam int OSC_LOCK_BIT = 6;
	localparam int CFG_1WAY_BIT = 5;
	localparam int ST_LOCK_BIT = 0;
	localparam int ST_ONCE_BIT = 1;
	localparam int ST_1WAY_BIT = 2;
	localparam int ST_ARMED_BIT = 3;
	localparam int ST_MISM_BIT = 4;
	localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
	localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
	localparam logic [NIO-1:0] IO_IMPL_FULL = 32'hFFFF_FFFF;
	localparam logic [NIO-1:0] IO_IMPL_SMALL = 32'h7FFF_7FDF;
	localparam logic [NRPI-1:0] RPI_IMPL_FULL = 12'hFFF;
	localparam logic [NRPI-1:0] RPI_IMPL_SMALL = 12'h020;
	localparam logic [SELW-1:0] IMAP_RST = 6'h3F;
	localparam logic [SELW-1:0] OMAP_RST = 6'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [1:0] SYNC_RST = 2'b00;

	typedef struct packed {
		logic [NIO-1:0] oe;
		logic [NIO-1:0] out;
	} iopr_pad_t;

	typedef enum logic [2:0] {
		UL_IDLE = 3'b001,
		UL_KEY1 = 3'b010,
		UL_ARMED = 3'b100
	} iopr_ul_t;
endpackage : iopr_pkg

// ==== verification/iopr_checker.sv ====
// Assertion checker for the pin port and remap block.
module iopr_checker
	import iopr_pkg::*;
#(
	parameter bit SMALL_PKG = 1'b0
) (
	input wire logic clk_i, // Clock.
	input wire logic resetn_i, // Reset.
	input wire logic s_axi_awvalid, // AW valid.
	input wire logic s_axi_awready, // AW ready.
	input wire logic s_axi_wvalid, // W valid.
	input wire logic s_axi_wready, // W ready.
	input wire logic s_axi_bvalid, // B valid.
	input wire logic s_axi_arvalid, // AR valid.
	input wire logic s_axi_arready, // AR ready.
	input wire logic s_axi_rvalid, // R valid.
	input wire logic s_axi_rready, // R ready.
	input iopr_pad_t pad_o, // Pads.
	input wire logic cfg_mismatch_reset_o // Mismatch.
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_banswer;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	AST_WANS: assert property (s_wtake |=> s_banswer)
		else $error("write answer not after two edges");
	AST_AWLOW: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready stayed high after take");
	AST_BWAIT: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write ready while response pending");
	AST_RANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_RDONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read not closed by handshake");
	AST_MISM: assert property (!cfg_mismatch_reset_o)
		else $error("mismatch reset without a fault");
	AST_IMPL: assert property (!SMALL_PKG || (pad_o.oe & ~IO_IMPL_SMALL) == '0)
		else $error("absent pin driven");
	AST_RSTOE: assert property (!$past(resetn_i) |-> pad_o.oe == '0 ##1 pad_o.oe == '0)
		else $error("pin driven after reset");
endmodule : iopr_checker

bind iopr_top iopr_checker #(.SMALL_PKG(SMALL_PKG)) i_iopr_checker (
	.clk_i,
	.resetn_i,
	.s_axi_awvalid,
	.s_axi_awready,
	.s_axi_wvalid,
	.s_axi_wready,
	.s_axi_bvalid,
	.s_axi_arvalid,
	.s_axi_arready,
	.s_axi_rvalid,
	.s_axi_rready,
	.pad_o,
	.cfg_mismatch_reset_o
);

// ==== verification/iopr_pins_model.sv ====
// Board side of the pads: each pad shows the block's level when enabled.
module iopr_pins_model
	import iopr_pkg::*;
(
	input iopr_pad_t pad_o, // Block drivers.
	input wire logic [NIO-1:0] ext_i, // External levels.
	output logic [NIO-1:0] pad_in_o // Pad levels.
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pad_in_o = (pad_o.oe & pad_o.out) | (~pad_o.oe & ext_i);
endmodule : iopr_pins_model

// ==== verification/testbench.sv ====
// Self-checking bench for the pin port and remap block.
module testbench
	import iopr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_d;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
	logic [7:0] osc_cfg_word_i = 8'h20;
	logic [NIO-1:0] pad_in_i, ext = 32'hCAFE_BEEF;
	logic [NRPI-1:0] rpi_in_i = 12'hFFF;
	logic [NFN-1:0] periph_out_i = '0, periph_drive_i = '0, periph_in_o;
	iopr_pad_t pad_o;
	logic cfg_mismatch_reset_o;
	int n_fail = 0, checks_done = 0;
	always #50 clk_i = ~clk_i;
	iopr_top #(.SMALL_PKG(1'b0)) i_iopr_top (.clk_i, .resetn_i, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .osc_cfg_word_i, .pad_in_i, .rpi_in_i, .pad_o, .periph_out_i,
		.periph_drive_i, .periph_in_o, .cfg_mismatch_reset_o);
	iopr_pins_model i_iopr_pins_model (.pad_o(pad_o), .ext_i(ext), .pad_in_o(pad_in_i));
	task automatic stop_test;
		$display("checks %0d failed %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic tout(input int n);
		if (n >= 60) begin
			n_fail++;
			stop_test();
		end
	endtask : tout
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 60);
		br = s_axi_bresp;
		tout(n);
	endtask : wr
	task automatic rd(input logic [AW-1:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 60);
		rd_d = s_axi_rdata;
		rr = s_axi_rresp;
		tout(n);
	endtask : rd
	task automatic rc(input string nm, input logic [AW-1:0] a, input logic [31:0] e);
		rd(a);
		chk(nm, e, rd_d);
	endtask : rc
	task automatic stb(input int b, input logic [31:0] e);
		rd(OFS_STAT);
		chk("stat", e, (rd_d >> b) & 32'h0000_0001);
	endtask : stb
	task automatic ulk(input logic [31:0] v);
		wr(OFS_OSC, 32'(UNLOCK_KEY1));
		wr(OFS_OSC, 32'(UNLOCK_KEY2));
		wr(OFS_OSC, v);
	endtask : ulk
	task automatic settle;
		// Pads take three sync edges, one filter edge and two output edges.
		repeat (6) @(posedge clk_i);
	endtask : settle
	task automatic do_rst(input logic [7:0] c);
		resetn_i <= 1'b0;
		osc_cfg_word_i <= c;
		repeat (8) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
	endtask : do_rst
	task automatic t_reset;
		rc("dir", OFS_DIR, IO_IMPL_FULL);
		rc("lat", OFS_LAT, 32'h0000_0000);
		stb(ST_1WAY_BIT, 32'h0000_0001);
		chk("oe", 32'h0000_0000, pad_o.oe);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_port;
		wr(OFS_LAT, 32'h1234_5678);
		wr(OFS_DIR, 32'hFFFF_0000);
		settle();
		rc("lat", OFS_LAT, 32'h1234_5678);
		chk("oe", 32'h0000_FFFF, pad_o.oe);
		rc("pin", OFS_PIN, 32'hCAFE_5678);
		wr(OFS_PIN, 32'h0000_5678);
		rc("lat", OFS_LAT, 32'h0000_5678);
		$display("t_port done");
	endtask : t_port
	task automatic t_remap;
		wr(OFS_IMAP, 32'h0000_0014);
		wr(OFS_IMAP + 12'h004, 32'h0000_0014);
		wr(OFS_IMAP + 12'h008, 32'h0000_0003);
		wr(OFS_IMAP + 12'h00C, 32'h0000_0030);
		wr(OFS_IMAP + 12'h010, 32'h0000_0020);
		wr(OFS_OMAP + 12'h010, 32'h0000_0001);
		wr(OFS_OMAP + 12'h018, 32'h0000_0001);
		wr(OFS_OMAP + 12'h040, 32'h0000_0001);
		periph_drive_i <= 8'h01;
		settle();
		chk("p_in", 32'h0000_0013, {24'h00_0000, periph_in_o});
		chk("oe", 32'h0001_FFFF, pad_o.oe);
		chk("out", 32'h0000_5628, pad_o.out);
		rc("pin", OFS_PIN, 32'hCAFE_5628);
		periph_out_i <= 8'h01;
		settle();
		chk("out", 32'h0001_5678, pad_o.out);
		rc("pin", OFS_PIN, 32'hCAFF_5678);
		periph_out_i <= 8'h00;
		periph_drive_i <= 8'h00;
		settle();
		chk("oe", 32'h0000_FFFF, pad_o.oe);
		chk("out", 32'h0000_5678, pad_o.out);
		$display("t_remap done");
	endtask : t_remap
	task automatic t_lock;
		ulk(32'h0000_0040);
		stb(ST_LOCK_BIT, 32'h0000_0001);
		wr(OFS_IMAP, 32'h0000_0005);
		chk("bresp", 32'(RESP_OKAY), 32'(br));
		rc("imap", OFS_IMAP, 32'h0000_0014);
		rc("osc", OFS_OSC, 32'h0000_0040);
		stb(ST_MISM_BIT, 32'h0000_0000);
		chk("mism", 32'h0000_0000, 32'(cfg_mismatch_reset_o));
		ulk(32'h0000_0000);
		stb(ST_LOCK_BIT, 32'h0000_0001);
		$display("t_lock done");
	endtask : t_lock
	task automatic t_multi;
		do_rst(8'h00);
		stb(ST_1WAY_BIT, 32'h0000_0000);
		ulk(32'h0000_0040);
		ulk(32'h0000_0000);
		stb(ST_LOCK_BIT, 32'h0000_0000);
		wr(OFS_OMAP, 32'h0000_0002);
		wr(OFS_IMAP, 32'h0000_0007);
		rc("imap", OFS_IMAP, 32'h0000_0007);
		wr(OFS_OSC, 32'(UNLOCK_KEY1));
		rd(OFS_STAT);
		wr(OFS_OSC, 32'(UNLOCK_KEY2));
		wr(OFS_OSC, 32'h0000_0040);
		stb(ST_LOCK_BIT, 32'h0000_0000);
		rc("unmapped", 12'h300, 32'h0000_0000);
		chk("rresp", 32'(RESP_SLVERR), 32'(rr));
		$display("t_multi done");
	endtask : t_multi
	initial begin
		do_rst(8'h20);
		t_reset();
		t_port();
		t_remap();
		t_lock();
		t_multi();
		stop_test();
	end
endmodule : testbench
